// ### design/mr_pkg.sv
// Constants and types shared by both ends of the mode-register link.
// Assumes one command on the link per link-clock cycle.
package mr_pkg;
    // Mode register addresses on the command/address bus.
    localparam logic [5:0] OSC_COUNT_LOW_ADDR  = 6'h12;
    localparam logic [5:0] OSC_COUNT_HIGH_ADDR = 6'h13;
    localparam logic [5:0] UPPER_INVERT_ADDR   = 6'h14;
    localparam logic [5:0] CA_BUFFER_ADDR      = 6'h15;
    // Field positions and values after reset.
    localparam int         LOW_SPEED_BIT       = 5;
    localparam logic [7:0] INVERT_RESET        = 8'h55;
    localparam logic [7:0] CA_BUFFER_RESET     = 8'h00;
    localparam logic [7:0] LOW_SPEED_MASK      = 8'h20;
    // Ceiling of the link clock while the low-speed buffer is in use.
    localparam int         LOW_SPEED_MAX_MHZ   = 800;
    // Core cycles per half period of the link clock.
    localparam int         LINK_DIV_CYCLES     = 2;
    // Controller register offsets.
    localparam logic [3:0] REG_MR_ADDR   = 4'h0;
    localparam logic [3:0] REG_MR_WDATA  = 4'h1;
    localparam logic [3:0] REG_COMMAND   = 4'h2;
    localparam logic [3:0] REG_STATUS    = 4'h3;
    localparam logic [3:0] REG_READ_BYTE = 4'h4;
    localparam logic [3:0] REG_COUNT_LO  = 4'h5;
    localparam logic [3:0] REG_COUNT_HI  = 4'h6;
    localparam logic [3:0] REG_CONFIG    = 4'h7;
    // Command register bits.
    localparam int CMD_WRITE_BIT   = 0;
    localparam int CMD_READ_BIT    = 1;
    localparam int CMD_START_BIT   = 2;
    localparam int CMD_MEASURE_BIT = 3;
    // Status and configuration bits.
    localparam int STAT_BUSY_BIT    = 0;
    localparam int STAT_MEASURE_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam int CFG_INIT_BIT     = 0;
    localparam int CFG_ODT_BIT      = 1;
    localparam int CFG_FAST_BIT     = 2;

    // Controller sequencer states; every step but CTRL_WAIT back to CTRL_IDLE changes one bit.
    typedef enum logic [1:0] {
        CTRL_IDLE = 2'b00,
        CTRL_SEND = 2'b01,
        CTRL_WAIT = 2'b11
    } ctrl_state_t;
endpackage

// ### design/mr_link_if.sv
// Link between the memory controller and the mode-register bank.
// The controller makes the link clock; the device samples on its rise.
`timescale 1ns/1ns
interface mr_link_if;
    logic       link_clk;
    logic       cmd_valid;
    logic       cmd_write;
    logic       cmd_mpc;
    logic [5:0] cmd_addr;
    logic [7:0] cmd_data;
    logic       rsp_valid;
    logic [7:0] rsp_data;

    modport controller (
        output link_clk,
        output cmd_valid,
        output cmd_write,
        output cmd_mpc,
        output cmd_addr,
        output cmd_data,
        input  rsp_valid,
        input  rsp_data
    );

    modport device (
        input  link_clk,
        input  cmd_valid,
        input  cmd_write,
        input  cmd_mpc,
        input  cmd_addr,
        input  cmd_data,
        output rsp_valid,
        output rsp_data
    );
endinterface

// ### design/mr_device.sv
// Mode-register bank of the memory device: oscillator count, upper-byte
// calibration invert and command/address buffer configuration.
// Assumes the controller changes the command lines away from the rising
// edge of the link clock; the oscillator and set-point bits come from
// logic on the link clock.
`timescale 1ns/1ns
module mr_device #(
    parameter bit LOW_SPEED_SUPPORTED = 1'b1
) (
    // Link to the controller.
    mr_link_if.device  link,
    // Control in the link clock domain.
    input  wire logic  link_resetn,
    input  wire logic  en,
    // Set-point selects.
    input  wire logic  write_set_point_select,
    input  wire logic  operating_set_point_select,
    // Strobe oscillator.
    input  wire logic        osc_load,
    input  wire logic [15:0] osc_count,
    output logic             osc_start,
    // Read calibration and buffer selection.
    input  wire logic        cal_active,
    input  wire logic        cal_pattern,
    input  wire logic        dbi_enable,
    output logic [7:0]       dq_cal,
    output logic             dmi_cal,
    output logic             dbi_active,
    output logic             ca_low_speed
);

    // All state of the bank.
    typedef struct packed {
        logic [7:0]      osc_lo;
        logic [7:0]      osc_hi;
        logic [7:0]      invert;
        logic [1:0][7:0] cfg;
        logic            rsp_valid;
        logic [7:0]      rsp_data;
        logic            osc_start;
        logic [7:0]      dq_cal;
        logic            dmi_cal;
        logic            dbi_active;
        logic            ca_low_speed;
    } dev_state_t;

    dev_state_t s_q;
    dev_state_t s_d;
    logic [7:0] lane_pat;

    // Answer to a read; write-only and unmapped addresses read as zero.
    function automatic logic [7:0] read_value(
        input logic [5:0] addr,
        input logic [7:0] lo,
        input logic [7:0] hi
    );
        logic [7:0] v;
        v = 8'h00;
        if (addr == mr_pkg::OSC_COUNT_LOW_ADDR) begin
            v = lo;
        end else if (addr == mr_pkg::OSC_COUNT_HIGH_ADDR) begin
            v = hi;
        end
        return v;
    endfunction

    // Buffer configuration as stored; reserved bits are kept at zero and
    // the select bit sticks at normal when the feature is absent.
    function automatic logic [7:0] cfg_value(input logic [7:0] data);
        logic [7:0] v;
        v = mr_pkg::CA_BUFFER_RESET;
        if (LOW_SPEED_SUPPORTED) begin
            v = data & mr_pkg::LOW_SPEED_MASK;
        end
        return v;
    endfunction

    // Each upper lane carries the pattern, flipped where its invert bit
    // is set; bit i drives lane 8+i.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_lane
            assign lane_pat[gi] = cal_pattern ^ s_q.invert[gi];
        end
    endgenerate

    // Next-state logic for commands, oscillator and calibration outputs.
    always_comb begin
        s_d = s_q;
        s_d.rsp_valid = 1'b0;
        s_d.osc_start = 1'b0;
        if (link.cmd_valid) begin
            if (link.cmd_mpc) begin
                s_d.osc_lo    = 8'h00;
                s_d.osc_hi    = 8'h00;
                s_d.osc_start = 1'b1;
            end else if (link.cmd_write) begin
                if (link.cmd_addr == mr_pkg::UPPER_INVERT_ADDR) begin
                    s_d.invert = link.cmd_data;
                end else if (link.cmd_addr == mr_pkg::CA_BUFFER_ADDR) begin
                    s_d.cfg[write_set_point_select] = cfg_value(link.cmd_data);
                end
            end else begin
                s_d.rsp_valid = 1'b1;
                s_d.rsp_data  = read_value(link.cmd_addr,
                                           s_q.osc_lo, s_q.osc_hi);
            end
        end
        // A finished measurement is not lost to a start in the same cycle.
        if (osc_load) begin
            s_d.osc_lo = osc_count[7:0];
            s_d.osc_hi = osc_count[15:8];
        end
        s_d.dq_cal     = cal_active ? lane_pat : 8'h00;
        s_d.dmi_cal    = cal_active & cal_pattern;
        s_d.dbi_active = dbi_enable & ~cal_active;
        s_d.ca_low_speed = s_q.cfg[operating_set_point_select][mr_pkg::LOW_SPEED_BIT];
    end

    // State register on the link clock; enable freezes everything.
    always_ff @(posedge link.link_clk) begin
        if (!link_resetn) begin
            s_q        <= '0;
            s_q.invert <= mr_pkg::INVERT_RESET;
        end else if (en) begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign link.rsp_valid = s_q.rsp_valid;
    assign link.rsp_data  = s_q.rsp_data;
    assign osc_start      = s_q.osc_start;
    assign dq_cal         = s_q.dq_cal;
    assign dmi_cal        = s_q.dmi_cal;
    assign dbi_active     = s_q.dbi_active;
    assign ca_low_speed   = s_q.ca_low_speed;

endmodule // mr_device

// ### design/mr_controller.sv
// Memory-controller end: software register port, link clock divider and
// a small sequencer for mode-register reads, writes and measurements.
// Assumes software uses the register port on core_clk.
//
// Functional notes
// - Register 12h reads low oscillator count byte.
// - Register 13h reads high oscillator count byte.
// - Controller reads both bytes and joins them.
// - Start-oscillator command clears both count bytes.
// - Controller may retune strobe phase from count.
// - Register 14h inverts upper lanes bit by bit.
// - Invert register holds 55h after reset.
// - Upper mask pin sends true pattern always.
// - No bus inversion during read calibration.
// - Register 15h bit 5 selects low-speed buffer.
// - Without support, buffer select writes are ignored.
// - Low-speed buffer limits clock to 800 MHz.
// - Writes update only the write set-point copy.
// - Device acts on operating set-point copy only.
// - Low-speed enable only after initialization completes.
// - Low-speed enable only with termination disabled.
`timescale 1ns/1ns
module mr_controller #(
    parameter int unsigned LINK_DIV = mr_pkg::LINK_DIV_CYCLES
) (
    // Clock, reset and enable.
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       en,
    // Software register port.
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Link to the device.
    mr_link_if.controller   link
);

    // All state of the controller.
    typedef struct packed {
        mr_pkg::ctrl_state_t st;
        logic [7:0]  div;
        logic        link_clk;
        logic        cmd_valid;
        logic        cmd_write;
        logic        cmd_mpc;
        logic [5:0]  cmd_addr;
        logic [7:0]  cmd_data;
        logic        sent;
        logic        measure;
        logic        phase;
        logic [5:0]  mr_addr;
        logic [7:0]  mr_wdata;
        logic [7:0]  rd_byte;
        logic [15:0] count;
        logic [2:0]  cfg;
        logic        refused;
        logic        rsp_s1;
        logic        rsp_s2;
        logic        rsp_s3;
        logic [7:0]  data_s1;
        logic [7:0]  data_s2;
        logic [7:0]  rdata;
    } ctrl_s_t;

    ctrl_s_t s_q;
    ctrl_s_t s_d;
    logic    tick;
    logic    fall;
    logic    rsp_edge;
    logic    ls_allowed;
    logic    ls_request;

    assign tick     = (s_q.div == 8'(LINK_DIV - 1));
    assign fall     = tick & s_q.link_clk;
    assign rsp_edge = s_q.rsp_s2 & ~s_q.rsp_s3;
    // Low-speed buffer only after init, without CA termination, slow clock.
    assign ls_allowed = s_q.cfg[mr_pkg::CFG_INIT_BIT] &
                        ~s_q.cfg[mr_pkg::CFG_ODT_BIT] &
                        ~s_q.cfg[mr_pkg::CFG_FAST_BIT];
    assign ls_request = (s_q.mr_addr == mr_pkg::CA_BUFFER_ADDR) &
                        s_q.mr_wdata[mr_pkg::LOW_SPEED_BIT];

    // Divider, synchronisers, register port and sequencer.
    always_comb begin
        s_d = s_q;
        s_d.div = tick ? 8'h00 : 8'(s_q.div + 8'h01);
        if (tick) begin
            s_d.link_clk = ~s_q.link_clk;
        end
        // Two-stage synchronisers on the answer; stage two is read, and a third valid stage finds the edge.
        s_d.rsp_s1  = link.rsp_valid;
        s_d.rsp_s2  = s_q.rsp_s1;
        s_d.rsp_s3  = s_q.rsp_s2;
        s_d.data_s1 = link.rsp_data;
        s_d.data_s2 = s_q.data_s1;
        // Register reads answer one cycle later.
        s_d.rdata = 8'h00;
        if (rd) begin
            unique case (addr)
                mr_pkg::REG_MR_ADDR:   s_d.rdata = {2'b00, s_q.mr_addr};
                mr_pkg::REG_MR_WDATA:  s_d.rdata = s_q.mr_wdata;
                mr_pkg::REG_STATUS:    s_d.rdata = {5'h00, s_q.refused,
                                         s_q.measure,
                                         s_q.st != mr_pkg::CTRL_IDLE};
                mr_pkg::REG_READ_BYTE: s_d.rdata = s_q.rd_byte;
                mr_pkg::REG_COUNT_LO:  s_d.rdata = s_q.count[7:0];
                mr_pkg::REG_COUNT_HI:  s_d.rdata = s_q.count[15:8];
                mr_pkg::REG_CONFIG:    s_d.rdata = {5'h00, s_q.cfg};
                default:               s_d.rdata = 8'h00;
            endcase
        end
        if (wr) begin
            if (addr == mr_pkg::REG_MR_ADDR) begin
                s_d.mr_addr = wdata[5:0];
            end else if (addr == mr_pkg::REG_MR_WDATA) begin
                s_d.mr_wdata = wdata;
            end else if (addr == mr_pkg::REG_CONFIG) begin
                s_d.cfg = wdata[2:0];
            end else if (addr == mr_pkg::REG_STATUS &&
                         wdata[mr_pkg::STAT_REFUSED_BIT]) begin
                s_d.refused = 1'b0;
            end
        end
        // Sequencer. A refusal and its clear are both register writes, so
        // they never fall in one cycle.
        unique case (s_q.st)
            mr_pkg::CTRL_IDLE: begin
                if (wr && addr == mr_pkg::REG_COMMAND) begin
                    s_d.sent = 1'b0;
                    s_d.cmd_write = 1'b0;
                    s_d.cmd_mpc   = 1'b0;
                    s_d.cmd_addr  = s_q.mr_addr;
                    s_d.cmd_data  = 8'h00;
                    if (wdata[mr_pkg::CMD_WRITE_BIT]) begin
                        // A low-speed enable outside its window is flagged.
                        if (ls_request && !ls_allowed) begin
                            s_d.refused = 1'b1;
                        end else begin
                            s_d.st = mr_pkg::CTRL_SEND;
                            s_d.cmd_write = 1'b1;
                            s_d.cmd_data = (s_q.mr_addr ==
                                mr_pkg::CA_BUFFER_ADDR) ?
                                (s_q.mr_wdata & mr_pkg::LOW_SPEED_MASK) :
                                s_q.mr_wdata;
                        end
                    end else if (wdata[mr_pkg::CMD_READ_BIT]) begin
                        s_d.st = mr_pkg::CTRL_SEND;
                    end else if (wdata[mr_pkg::CMD_START_BIT]) begin
                        s_d.st = mr_pkg::CTRL_SEND;
                        s_d.cmd_mpc = 1'b1;
                    end else if (wdata[mr_pkg::CMD_MEASURE_BIT]) begin
                        s_d.st = mr_pkg::CTRL_SEND;
                        s_d.measure = 1'b1;
                        s_d.phase = 1'b0;
                        s_d.cmd_addr = mr_pkg::OSC_COUNT_LOW_ADDR;
                    end
                end
            end
            mr_pkg::CTRL_SEND: begin
                // Command valid changes at the falling link edge only.
                if (fall) begin
                    s_d.cmd_valid = ~s_q.sent;
                    s_d.sent = 1'b1;
                    if (s_q.sent) begin
                        s_d.st = (s_q.cmd_write || s_q.cmd_mpc) ?
                                 mr_pkg::CTRL_IDLE : mr_pkg::CTRL_WAIT;
                    end
                end
            end
            mr_pkg::CTRL_WAIT: begin
                if (rsp_edge) begin
                    s_d.rd_byte = s_q.data_s2;
                    s_d.st = mr_pkg::CTRL_IDLE;
                    // The low count byte is followed at once by the high.
                    if (s_q.measure && !s_q.phase) begin
                        s_d.count[7:0] = s_q.data_s2;
                        s_d.phase = 1'b1;
                        s_d.sent = 1'b0;
                        s_d.cmd_addr = mr_pkg::OSC_COUNT_HIGH_ADDR;
                        s_d.st = mr_pkg::CTRL_SEND;
                    end else if (s_q.measure) begin
                        s_d.count[15:8] = s_q.data_s2;
                        s_d.measure = 1'b0;
                    end
                end
            end
            default: s_d.st = mr_pkg::CTRL_IDLE;
        endcase
    end

    // State register; enable freezes everything.
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            s_q <= '0;
        end else if (en) begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    assign rdata          = s_q.rdata;
    assign link.link_clk  = s_q.link_clk;
    assign link.cmd_valid = s_q.cmd_valid;
    assign link.cmd_write = s_q.cmd_write;
    assign link.cmd_mpc   = s_q.cmd_mpc;
    assign link.cmd_addr  = s_q.cmd_addr;
    assign link.cmd_data  = s_q.cmd_data;

endmodule // mr_controller

// ### testbench/mr_link_asserts.sv
// Checker for the mode-register link between controller and device.
// Assumes the link signals and the link-domain reset as plain inputs.
`timescale 1ns/1ns
module mr_link_asserts (
    // Link clock domain.
    input wire logic       link_clk,
    input wire logic       link_resetn,
    // Command and answer lines.
    input wire logic       cmd_valid,
    input wire logic       cmd_write,
    input wire logic       cmd_mpc,
    input wire logic [5:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    input wire logic       rsp_valid,
    input wire logic [7:0] rsp_data
);
    logic rd_cmd;
    logic wr_cfg;

    // Decodes a plain read and a write to the buffer register.
    assign rd_cmd = cmd_valid && !cmd_write && !cmd_mpc;
    assign wr_cfg = cmd_valid && cmd_write && !cmd_mpc
                    && cmd_addr == mr_pkg::CA_BUFFER_ADDR;

    default clocking cb @(posedge link_clk); endclocking
    default disable iff (!link_resetn);

    a_read_answered: assert property (rd_cmd |=> rsp_valid)
        else $error("read command not answered");
    a_no_stray: assert property (!rd_cmd |=> !rsp_valid)
        else $error("answer without a read command");
    a_data_held: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("read data moved between answers");
    a_invert_wo: assert property (
        rd_cmd && cmd_addr == mr_pkg::UPPER_INVERT_ADDR |=> rsp_data == 8'h00)
        else $error("write-only invert register read nonzero");
    a_buffer_wo: assert property (
        rd_cmd && cmd_addr == mr_pkg::CA_BUFFER_ADDR |=> rsp_data == 8'h00)
        else $error("write-only buffer register read nonzero");
    a_reserved_zero: assert property (
        wr_cfg |-> (cmd_data & ~mr_pkg::LOW_SPEED_MASK) == 8'h00)
        else $error("reserved buffer bits written nonzero");
    a_count_pair: assert property (
        rd_cmd && cmd_addr == mr_pkg::OSC_COUNT_LOW_ADDR
        |-> ##[1:16] (rd_cmd && cmd_addr == mr_pkg::OSC_COUNT_HIGH_ADDR))
        else $error("low count byte read without high byte");
    a_write_single: assert property (
        cmd_valid && cmd_write |=> !cmd_valid)
        else $error("write command held beyond one link cycle");

    // Main traffic kinds seen on the link.
    c_read: cover property (rd_cmd ##1 rsp_valid);
    c_start: cover property (cmd_valid && cmd_mpc);
    c_cfg_write: cover property (wr_cfg && cmd_data == 8'h20);
endmodule // mr_link_asserts

// ### testbench/testbench.sv
// Testbench joining controller and device over the mode-register link.
// Assumes software drives the register port on core_clk.
`timescale 1ns/1ns
module testbench;
    typedef struct packed {
        logic [7:0] inv;
        logic       pat;
        logic [7:0] dq;
    } row_t;

    logic        core_clk, resetn, link_resetn, wr, rd;
    logic [3:0]  addr;
    logic [7:0]  wdata, rdata, rb, dq_cal;
    logic        write_set_point_select, operating_set_point_select, osc_load, osc_start, cal_active;
    logic        cal_pattern, dbi_enable, dmi_cal, dbi_active, ca_low_speed;
    logic [15:0] osc_count;
    int          error_cnt = 0;
    int          cmp_count = 0;
    int          start_cnt = 0;
    row_t        rows [5] = '{'{8'h15, 1'b0, 8'h15}, '{8'h15, 1'b1, 8'hea},
        '{8'hf0, 1'b0, 8'hf0}, '{8'h0f, 1'b1, 8'hf0}, '{8'hff, 1'b1, 8'h00}};
    logic [7:0]  bad [3] = '{8'h00, 8'h03, 8'h05};

    mr_link_if link_if ();

    mr_controller mr_controller_inst (.core_clk(core_clk), .resetn(resetn),
        .en(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .link(link_if));

    mr_device mr_device_inst (.link(link_if), .link_resetn(link_resetn),
        .en(1'b1), .write_set_point_select(write_set_point_select), .operating_set_point_select(operating_set_point_select), .osc_load(osc_load),
        .osc_count(osc_count), .osc_start(osc_start),
        .cal_active(cal_active), .cal_pattern(cal_pattern),
        .dbi_enable(dbi_enable), .dq_cal(dq_cal), .dmi_cal(dmi_cal),
        .dbi_active(dbi_active), .ca_low_speed(ca_low_speed));

    mr_link_asserts mr_link_asserts_inst (.link_clk(link_if.link_clk),
        .link_resetn(link_resetn), .cmd_valid(link_if.cmd_valid),
        .cmd_write(link_if.cmd_write), .cmd_mpc(link_if.cmd_mpc),
        .cmd_addr(link_if.cmd_addr), .cmd_data(link_if.cmd_data),
        .rsp_valid(link_if.rsp_valid), .rsp_data(link_if.rsp_data));

    // Counts oscillator start pulses from the device.
    always @(posedge osc_start) begin
        start_cnt++;
    end

    // Compares a byte result and counts it.
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask

    // Compares a single-bit result and counts it.
    task automatic check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t bit got %b exp %b", $time, got, exp);
        end
    endtask

    // One register write cycle on the software port.
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask

    // One register read cycle; data are taken in the following cycle.
    task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(negedge core_clk);
        d = rdata;
    endtask

    // Issues a command, polls busy under a bound, lets the link settle.
    task automatic run(input logic [7:0] c);
        logic [7:0] s;
        reg_wr(mr_pkg::REG_COMMAND, c);
        s = 8'h01;
        for (int i = 0; i < 100 && s[0] !== 1'b0; i++) begin
            reg_rd(mr_pkg::REG_STATUS, s);
        end
        check_bit(s[mr_pkg::STAT_BUSY_BIT], 1'b0);
        repeat (12) @(posedge core_clk);
    endtask

    // Mode register write through the controller.
    task automatic mode_register_write(input logic [5:0] a, input logic [7:0] d);
        reg_wr(mr_pkg::REG_MR_ADDR, {2'b00, a});
        reg_wr(mr_pkg::REG_MR_WDATA, d);
        run(8'h01);
    endtask

    // Prints the verdict and ends the run.
    task automatic final_report();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Core clock at 20 MHz.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Cuts a hang short.
    initial begin
        #2_000_000;
        error_cnt++;
        final_report();
    end

    // Main sequence; device inputs change on the falling core edge.
    initial begin
        {resetn, link_resetn, wr, rd, write_set_point_select, operating_set_point_select, osc_load} = '0;
        {cal_active, cal_pattern, addr, wdata, osc_count} = '0;
        dbi_enable = 1'b1;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        link_resetn <= 1'b1;
        cal_active  <= 1'b1;
        repeat (12) @(posedge core_clk);
        check_byte(dq_cal, mr_pkg::INVERT_RESET);
        check_bit(ca_low_speed, 1'b0);
        reg_rd(4'hf, rb);
        check_byte(rb, 8'h00);
        foreach (rows[i]) begin
            mode_register_write(mr_pkg::UPPER_INVERT_ADDR, rows[i].inv);
            @(negedge core_clk);
            cal_pattern <= rows[i].pat;
            repeat (12) @(posedge core_clk);
            check_byte(dq_cal, rows[i].dq);
            check_bit(dmi_cal, rows[i].pat);
            check_bit(dbi_active, 1'b0);
        end
        // Load a count, measure it, then clear it with a start.
        @(negedge core_clk);
        osc_count <= 16'h1234;
        osc_load  <= 1'b1;
        cal_active <= 1'b0;
        repeat (4) @(negedge core_clk);
        osc_load <= 1'b0;
        check_bit(dbi_active, 1'b1);
        run(8'h08);
        reg_rd(mr_pkg::REG_COUNT_LO, rb);
        check_byte(rb, 8'h34);
        reg_rd(mr_pkg::REG_COUNT_HI, rb);
        check_byte(rb, 8'h12);
        run(8'h04);
        check_byte(8'(start_cnt), 8'h01);
        run(8'h08);
        reg_rd(mr_pkg::REG_COUNT_LO, rb);
        check_byte(rb, 8'h00);
        reg_rd(mr_pkg::REG_COUNT_HI, rb);
        check_byte(rb, 8'h00);
        reg_wr(mr_pkg::REG_MR_ADDR, {2'b00, mr_pkg::UPPER_INVERT_ADDR});
        run(8'h02);
        reg_rd(mr_pkg::REG_READ_BYTE, rb);
        check_byte(rb, 8'h00);
        // Set-point copies of the buffer select.
        reg_wr(mr_pkg::REG_CONFIG, 8'h01);
        @(negedge core_clk);
        operating_set_point_select <= 1'b1;
        mode_register_write(mr_pkg::CA_BUFFER_ADDR, 8'h20);
        check_bit(ca_low_speed, 1'b0);
        @(negedge core_clk);
        operating_set_point_select <= 1'b0;
        repeat (12) @(posedge core_clk);
        check_bit(ca_low_speed, 1'b1);
        @(negedge core_clk);
        write_set_point_select <= 1'b1;
        mode_register_write(mr_pkg::CA_BUFFER_ADDR, 8'h00);
        check_bit(ca_low_speed, 1'b1);
        // Enables before init, with termination or at high clock refused.
        foreach (bad[i]) begin
            reg_wr(mr_pkg::REG_CONFIG, bad[i]);
            mode_register_write(mr_pkg::CA_BUFFER_ADDR, 8'h20);
            reg_rd(mr_pkg::REG_STATUS, rb);
            check_bit(rb[mr_pkg::STAT_REFUSED_BIT], 1'b1);
            reg_wr(mr_pkg::REG_STATUS, 8'h04);
            reg_rd(mr_pkg::REG_STATUS, rb);
            check_bit(rb[mr_pkg::STAT_REFUSED_BIT], 1'b0);
        end
        @(negedge core_clk);
        operating_set_point_select <= 1'b1;
        repeat (12) @(posedge core_clk);
        check_bit(ca_low_speed, 1'b0);
        // A mid-run reset of the bank restores its values after reset.
        @(negedge core_clk);
        link_resetn <= 1'b0;
        operating_set_point_select      <= 1'b0;
        cal_pattern <= 1'b0;
        cal_active  <= 1'b1;
        repeat (12) @(posedge core_clk);
        @(negedge core_clk);
        link_resetn <= 1'b1;
        repeat (12) @(posedge core_clk);
        check_byte(dq_cal, mr_pkg::INVERT_RESET);
        check_bit(ca_low_speed, 1'b0);
        final_report();
    end
endmodule // testbench
